// *** src/aftm_consts.svh ***
// constants for the axis fault trap monitor
`ifndef AFTM_CONSTS_SVH
`define AFTM_CONSTS_SVH
// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define AFTM_AXES 4
`define AFTM_OUTS 8
`define AFTM_FULL_SCALE 16'h7FFF
`define AFTM_PCT_MAX 7'h64
`define AFTM_TIME_MIN 14'h0001
// ----------------------------------------------------------------
// timing: servo sample period is one millisecond
// ----------------------------------------------------------------
`define AFTM_CLK_HZ 40000000
`define AFTM_SAMPLE_US 1000
`define AFTM_MS_CYCLES (`AFTM_CLK_HZ / 1000000 * `AFTM_SAMPLE_US)
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define AFTM_ILIM_RST 23'h0A0000
`define AFTM_RMS_PCT_RST 7'h1E
`define AFTM_RMS_TIME_RST 14'h2710
`define AFTM_CLAMP_RST 7'h64
`define AFTM_SEL_AX0_RST 4'h1
`define AFTM_SEL_RST 4'h0
`define AFTM_AUXM_RST 2'h0
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define AFTM_OFF_STATUS 8'h00
`define AFTM_OFF_IRQ_MASK 8'h04
`define AFTM_OFF_OUT_STATE 8'h08
`define AFTM_AXIS_STRIDE 8'h20
`define AFTM_OFF_ILIM 5'h00
`define AFTM_OFF_RMS_PCT 5'h04
`define AFTM_OFF_RMS_TIME 5'h08
`define AFTM_OFF_CLAMP 5'h0C
`define AFTM_OFF_AUX_SEL 5'h10
`define AFTM_OFF_AUX_MASK 5'h14
// ----------------------------------------------------------------
// fault bit positions inside one axis pair
// ----------------------------------------------------------------
`define AFTM_BIT_INT 0
`define AFTM_BIT_RMS 1
`endif

// *** src/aftm_pkg.sv ***
// types shared by the axis fault trap monitor
package aftm_pkg;
   typedef logic [22:0] aftm_ilim_t;
   typedef logic [6:0] aftm_pct_t;
   typedef logic [13:0] aftm_time_t;
   typedef logic [3:0] aftm_sel_t;
   typedef logic [1:0] aftm_fbits_t;
   typedef logic signed [31:0] aftm_ierr_t;
   typedef logic signed [15:0] aftm_drive_t;
endpackage : aftm_pkg

// *** src/aftm_tick_div.sv ***
// divider giving a one-cycle sample enable
`timescale 1ns/100ps
module aftm_tick_div #(
   parameter int DIV = 40000
) (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   output logic tick // one-cycle enable per period
);
   logic [31:0] cnt;

   // free running count, wraps at DIV-1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 32'h0;
         tick <= 1'b0;
      end else begin
         tick <= (cnt == 32'(DIV - 1));
         cnt <= (cnt == 32'(DIV - 1)) ? 32'h0 : cnt + 32'h1;
      end
   end
endmodule : aftm_tick_div

// *** src/aftm_axis_trap.sv ***
// one axis: integral trap, output clamp and rms current trap
`timescale 1ns/100ps
`include "aftm_consts.svh"
module aftm_axis_trap (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire logic ms_tick, // servo sample enable
   input wire aftm_pkg::aftm_ierr_t int_err, // accumulated integral error
   input wire aftm_pkg::aftm_drive_t loop_in, // raw control-loop output
   input wire aftm_pkg::aftm_ilim_t ilim, // integral error limit
   input wire aftm_pkg::aftm_pct_t rms_pct, // rms limit percent
   input wire aftm_pkg::aftm_time_t rms_time, // rms window in ms
   input wire aftm_pkg::aftm_pct_t clamp_pct, // clamp percent
   output aftm_pkg::aftm_drive_t loop_out, // clamped drive
   output logic int_fault, // integral limit exceeded, level
   output logic rms_fault // rms window trip, one-cycle pulse
);
   import aftm_pkg::*;

   // ----------------------------------------------------------------
   // magnitudes and limits
   // ----------------------------------------------------------------
   wire [31:0] ierr_mag = int_err[31] ? 32'(-int_err) : 32'(int_err);
   wire [16:0] in_mag = loop_in[15] ? 17'(-32'(loop_in)) : 17'(loop_in);
   wire [15:0] clamp_lvl = 16'((32'(clamp_pct) * 32'(`AFTM_FULL_SCALE)) / 32'(`AFTM_PCT_MAX));
   wire [15:0] rms_lvl = 16'((32'(rms_pct) * 32'(`AFTM_FULL_SCALE)) / 32'(`AFTM_PCT_MAX));
   wire over_clamp = in_mag > 17'(clamp_lvl);
   wire [15:0] out_mag = loop_out[15] ? 16'(-32'(loop_out)) : 16'(loop_out);
   wire [31:0] sq = 32'(out_mag) * 32'(out_mag);
   wire [47:0] thr = 48'(32'(rms_lvl) * 32'(rms_lvl)) * 48'(rms_time);
   wire rms_off = rms_pct >= `AFTM_PCT_MAX;
   logic [47:0] acc;
   logic [13:0] win;
   wire [47:0] next_acc = acc + 48'(sq);
   wire win_end = (win + 14'h1) >= rms_time;
   wire trip = ms_tick && !rms_off && (next_acc > thr);

   // integral trap and clamp; saturation alone raises nothing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_fault <= 1'b0;
         loop_out <= 16'sh0000;
      end else begin
         int_fault <= ierr_mag > 32'(ilim);
         loop_out <= !over_clamp ? loop_in :
            (loop_in[15] ? -$signed(clamp_lvl) : $signed(clamp_lvl));
      end
   end

   // squares summed over the window; early trip on the same threshold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= 48'h0;
         win <= 14'h0;
         rms_fault <= 1'b0;
      end else begin
         rms_fault <= trip;
         if (ms_tick) begin
            acc <= (trip || win_end) ? 48'h0 : next_acc;
            win <= (trip || win_end) ? 14'h0 : win + 14'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_clamp_bound: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (out_mag <= $past(clamp_lvl)))
      else $error("drive above clamp level");
   a_int_trap: assert property (@(posedge pclk) disable iff (!presetn)
      (ierr_mag > 32'(ilim)) |=> int_fault)
      else $error("integral fault missed");
   a_rms_never: assert property (@(posedge pclk) disable iff (!presetn)
      rms_off |=> !rms_fault)
      else $error("rms fault at full limit");
   a_rms_cause: assert property (@(posedge pclk) disable iff (!presetn)
      rms_fault |-> $past(ms_tick) && !$past(rms_off))
      else $error("rms fault without sample");
   a_win_bound: assert property (@(posedge pclk) disable iff (!presetn)
      ms_tick && win_end |=> win == 14'h0 && acc == 48'h0)
      else $error("rms window not restarted");
endmodule : aftm_axis_trap

// *** src/aftm_top.sv ***
// axis fault trap monitor: apb registers, four axis traps, aux outputs
//
// Operation
// - Each axis flags integral fault while integral error magnitude exceeds its limit.
// - Integral limit range 0 to 8388607, reset value 655360.
// - RMS limit is percent 0..100 of full-scale drive output.
// - RMS fault when RMS drive stays over limit the whole window.
// - Fault early once accumulated square exceeds limit squared times window.
// - RMS limit percent resets to thirty for every axis.
// - RMS limit of one hundred percent never raises an RMS fault.
// - RMS window 1 to 16383 ms, reset value 10000 ms.
// - Drive output magnitude saturates at clamp percent of full scale.
// - Clamp percent 0 to 100, reset value 100 meaning a clamp at full scale 32767.
// - Reaching the clamp level raises no fault by itself.
// - Aux selector zero disables the aux output for that axis.
// - Selector n from 1..8 drives output bit n-1 low; axis one resets to 1.
// - Reset drives every general output bit high.
// - Only faults enabled in the axis aux mask drive the output; mask resets clear.
`timescale 1ns/100ps
`include "aftm_consts.svh"
module aftm_top #(
   parameter int MS_CYCLES = `AFTM_MS_CYCLES
) (
   input wire logic pclk, // system clock, 40 MHz
   input wire logic presetn, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb access phase
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error on unmapped address
   input wire aftm_pkg::aftm_ierr_t int_err [`AFTM_AXES], // integral error per axis
   input wire aftm_pkg::aftm_drive_t loop_in [`AFTM_AXES], // raw loop output per axis
   output aftm_pkg::aftm_drive_t loop_out [`AFTM_AXES], // clamped loop output
   output logic [`AFTM_OUTS-1:0] gpo_n, // general outputs, active low
   output logic irq // level interrupt
);
   import aftm_pkg::*;

   // ----------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------
   aftm_ilim_t ilim [`AFTM_AXES];
   aftm_pct_t rms_pct [`AFTM_AXES];
   aftm_time_t rms_time [`AFTM_AXES];
   aftm_pct_t clamp_pct [`AFTM_AXES];
   aftm_sel_t aux_sel [`AFTM_AXES];
   aftm_fbits_t aux_mask [`AFTM_AXES];
   logic [2*`AFTM_AXES-1:0] status;
   logic [2*`AFTM_AXES-1:0] irq_mask;
   logic [2*`AFTM_AXES-1:0] event_now;
   logic [`AFTM_OUTS-1:0] next_gpo_n;
   logic ms_tick;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   // axis index from address: block number minus one, so the global block wraps to 7
   function automatic logic [2:0] axis_of(input logic [7:0] a);
      logic [2:0] ax;
      ax = 3'(a[7:5]) - 3'h1;
      return ax;
   endfunction : axis_of

   // true when the word inside an axis block is one of ours
   function automatic logic axis_word_ok(input logic [7:0] a);
      logic ok;
      ok = (a[4:0] <= `AFTM_OFF_AUX_MASK) && (a[1:0] == 2'h0);
      return ok && (a >= `AFTM_AXIS_STRIDE) && (a[7:5] <= 3'(`AFTM_AXES));
   endfunction : axis_word_ok

   wire setup = psel && !penable;
   wire access = psel && penable;
   wire glob_hit = (paddr == `AFTM_OFF_STATUS) || (paddr == `AFTM_OFF_IRQ_MASK)
      || (paddr == `AFTM_OFF_OUT_STATE);
   wire addr_ok = glob_hit || axis_word_ok(paddr);
   wire wr = access && pwrite && addr_ok;
   wire [2:0] wax = axis_of(paddr);
   wire [4:0] woff = paddr[4:0];

   // write values coerced into their legal ranges
   wire [6:0] wr_pct = (pwdata[31:0] > 32'(`AFTM_PCT_MAX)) ? `AFTM_PCT_MAX : pwdata[6:0];
   wire [13:0] wr_time = (pwdata[13:0] == 14'h0) ? `AFTM_TIME_MIN : pwdata[13:0];

   // zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = access && !addr_ok;

   // ----------------------------------------------------------------
   // per-axis registers and traps
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `AFTM_AXES; g++) begin : gen_axis
         wire hit = wr && (wax == 3'(g));
         logic int_f;
         logic rms_f;

         // settings written by software; axis one has its own selector default
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ilim[g] <= `AFTM_ILIM_RST;
               rms_pct[g] <= `AFTM_RMS_PCT_RST;
               rms_time[g] <= `AFTM_RMS_TIME_RST;
               clamp_pct[g] <= `AFTM_CLAMP_RST;
               aux_sel[g] <= (g == 0) ? `AFTM_SEL_AX0_RST : `AFTM_SEL_RST;
               aux_mask[g] <= `AFTM_AUXM_RST;
            end else if (hit) begin
               if (woff == `AFTM_OFF_ILIM) ilim[g] <= pwdata[22:0];
               if (woff == `AFTM_OFF_RMS_PCT) rms_pct[g] <= wr_pct;
               if (woff == `AFTM_OFF_RMS_TIME) rms_time[g] <= wr_time;
               if (woff == `AFTM_OFF_CLAMP) clamp_pct[g] <= wr_pct;
               if (woff == `AFTM_OFF_AUX_SEL) aux_sel[g] <= pwdata[3:0];
               if (woff == `AFTM_OFF_AUX_MASK) aux_mask[g] <= pwdata[1:0];
            end
         end

         // each axis owns its own trap and accumulator
         aftm_axis_trap u_trap (
            .pclk(pclk),
            .presetn(presetn),
            .ms_tick(ms_tick),
            .int_err(int_err[g]),
            .loop_in(loop_in[g]),
            .ilim(ilim[g]),
            .rms_pct(rms_pct[g]),
            .rms_time(rms_time[g]),
            .clamp_pct(clamp_pct[g]),
            .loop_out(loop_out[g]),
            .int_fault(int_f),
            .rms_fault(rms_f)
         );
         assign event_now[2*g+`AFTM_BIT_INT] = int_f;
         assign event_now[2*g+`AFTM_BIT_RMS] = rms_f;
      end
   endgenerate

   // sample period enable shared by all axes
   aftm_tick_div #(.DIV(MS_CYCLES)) u_div (
      .pclk(pclk),
      .presetn(presetn),
      .tick(ms_tick)
   );

   // ----------------------------------------------------------------
   // status, mask and interrupt
   // ----------------------------------------------------------------
   wire st_clr = wr && (paddr == `AFTM_OFF_STATUS);
   wire [2*`AFTM_AXES-1:0] clr_bits = st_clr ? pwdata[2*`AFTM_AXES-1:0] : '0;
   wire [2*`AFTM_AXES-1:0] next_status = (status & ~clr_bits) | event_now;
   // the interrupt uses the mask as it stands after this edge, so it never lags a mask write
   wire mask_wr = wr && (paddr == `AFTM_OFF_IRQ_MASK);
   wire [2*`AFTM_AXES-1:0] next_irq_mask = mask_wr ? pwdata[2*`AFTM_AXES-1:0] : irq_mask;

   // sticky faults; an event in the clearing cycle wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= '0;
         irq_mask <= '0;
         irq <= 1'b0;
      end else begin
         status <= next_status;
         irq_mask <= next_irq_mask;
         irq <= |(next_status & next_irq_mask);
      end
   end

   // ----------------------------------------------------------------
   // auxiliary fault outputs
   // ----------------------------------------------------------------
   // a masked sticky fault pulls the chosen line low until cleared
   always_comb begin
      next_gpo_n = '1;
      for (int a = 0; a < `AFTM_AXES; a++) begin
         for (int b = 0; b < `AFTM_OUTS; b++) begin
            if (aux_sel[a] == 4'(b + 1) && |(status[2*a +: 2] & aux_mask[a]))
               next_gpo_n[b] = 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) gpo_n <= '1;
      else gpo_n <= next_gpo_n;
   end

   // ----------------------------------------------------------------
   // read data, registered in the setup phase
   // ----------------------------------------------------------------
   wire [2:0] rax = axis_of(paddr);
   wire [1:0] rsel = rax[1:0];
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0;
      if (paddr == `AFTM_OFF_STATUS) rd_mux = 32'(status);
      else if (paddr == `AFTM_OFF_IRQ_MASK) rd_mux = 32'(irq_mask);
      else if (paddr == `AFTM_OFF_OUT_STATE) rd_mux = 32'(gpo_n);
      else if (axis_word_ok(paddr)) begin
         case (paddr[4:0])
            `AFTM_OFF_ILIM: rd_mux = 32'(ilim[rsel]);
            `AFTM_OFF_RMS_PCT: rd_mux = 32'(rms_pct[rsel]);
            `AFTM_OFF_RMS_TIME: rd_mux = 32'(rms_time[rsel]);
            `AFTM_OFF_CLAMP: rd_mux = 32'(clamp_pct[rsel]);
            `AFTM_OFF_AUX_SEL: rd_mux = 32'(aux_sel[rsel]);
            `AFTM_OFF_AUX_MASK: rd_mux = 32'(aux_mask[rsel]);
            default: rd_mux = 32'h0;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0;
      else if (setup && !pwrite) prdata <= rd_mux;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_status_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      status[0] && !(st_clr && pwdata[0]) |=> status[0])
      else $error("status bit lost without clear");
   a_aux_drive: assert property (@(posedge pclk) disable iff (!presetn)
      aux_sel[0] == 4'h1 && (status[1:0] & aux_mask[0]) != 2'h0 |=> !gpo_n[0])
      else $error("aux output not driven low");
   a_aux_idle: assert property (@(posedge pclk) disable iff (!presetn)
      (aux_mask[0] | aux_mask[1] | aux_mask[2] | aux_mask[3]) == 2'h0 |=> gpo_n == 8'hFF)
      else $error("aux output low with empty masks");
   a_aux_off: assert property (@(posedge pclk) disable iff (!presetn)
      aux_sel[0] == 4'h0 && aux_sel[1] == 4'h0 && aux_sel[2] == 4'h0
      && aux_sel[3] == 4'h0 |=> gpo_n == 8'hFF)
      else $error("aux output low with all selectors off");
   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 (irq == |(status & irq_mask)))
      else $error("interrupt does not follow status");
   a_rms_range: assert property (@(posedge pclk) disable iff (!presetn)
      rms_time[0] != 14'h0 && rms_pct[0] <= 7'h64 && clamp_pct[0] <= 7'h64)
      else $error("setting outside legal range");
endmodule : aftm_top

// *** dv/aftm_amp_model.sv ***
// drive amplifier model facing the axis fault trap monitor
`timescale 1ns/100ps
`include "aftm_consts.svh"
module aftm_amp_model (
   input wire logic pclk, // system clock
   input wire logic presetn, // async reset, active low
   input wire aftm_pkg::aftm_ierr_t ierr_cmd [`AFTM_AXES], // integral error to present
   input wire aftm_pkg::aftm_drive_t drive_cmd [`AFTM_AXES], // loop demand to present
   input wire aftm_pkg::aftm_drive_t loop_out [`AFTM_AXES], // clamped drive from monitor
   output aftm_pkg::aftm_ierr_t int_err [`AFTM_AXES], // integral error to monitor
   output aftm_pkg::aftm_drive_t loop_in [`AFTM_AXES], // loop demand to monitor
   output aftm_pkg::aftm_drive_t amp_seen [`AFTM_AXES] // drive as the amplifier latched it
);
   import aftm_pkg::*;
   // ----------------------------------------------------------------
   // sampled servo front end
   // ----------------------------------------------------------------
   // readings move once per clock, so the monitor never sees a mid-cycle change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_err <= '{default: '0};
         loop_in <= '{default: '0};
         amp_seen <= '{default: '0};
      end else begin
         for (int a = 0; a < `AFTM_AXES; a++) begin
            int_err[a] <= ierr_cmd[a];
            loop_in[a] <= drive_cmd[a];
            amp_seen[a] <= loop_out[a]; // the amplifier only ever sees the clamped drive
         end
      end
   end
endmodule : aftm_amp_model

// *** dv/tb_axis_fault_trap_monitor.sv ***
// self-checking testbench for the axis fault trap monitor
`timescale 1ns/100ps
`include "aftm_consts.svh"
module tb_axis_fault_trap_monitor;
   import aftm_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, irq, er;
   logic [7:0] gpo_n;
   aftm_ierr_t int_err [4];
   aftm_ierr_t ierr_cmd [4] = '{default: '0};
   aftm_drive_t drive_cmd [4] = '{default: '0};
   aftm_drive_t loop_in [4], loop_out [4], amp_seen [4];
   logic [4:0] roff [6] = '{`AFTM_OFF_ILIM, `AFTM_OFF_RMS_PCT, `AFTM_OFF_RMS_TIME,
      `AFTM_OFF_CLAMP, `AFTM_OFF_AUX_SEL, `AFTM_OFF_AUX_MASK};
   logic [31:0] rval [6] = '{32'hA0000, 32'h1E, 32'h2710, 32'h64, 32'h0, 32'h0};
   int err_total = 0;
   int n_compared = 0;
   int cyc;
   always #12.5 pclk = ~pclk;
   aftm_top #(.MS_CYCLES(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .int_err(int_err), .loop_in(loop_in),
      .loop_out(loop_out), .gpo_n(gpo_n), .irq(irq));
   aftm_amp_model amp (.pclk(pclk), .presetn(presetn), .ierr_cmd(ierr_cmd),
      .drive_cmd(drive_cmd), .loop_out(loop_out), .int_err(int_err), .loop_in(loop_in),
      .amp_seen(amp_seen));
   // ----------------------------------------------------------------
   // tasks and expectation functions
   // ----------------------------------------------------------------
   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one apb transfer; the request is held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         err_total++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask : cycles
   // bounded watch of the interrupt line; cyc equals lim when it never rose
   task automatic wait_irq(input int lim);
      for (cyc = 0; cyc < lim; cyc++) begin
         @(posedge pclk);
         if (irq === 1'b1) break;
      end
   endtask : wait_irq
   function automatic logic [7:0] ax(input int a, input logic [4:0] off);
      return 8'(`AFTM_AXIS_STRIDE * (a + 1)) + 8'(off);
   endfunction : ax
   task automatic wr_rd(input int a, input logic [4:0] off, input logic [31:0] d,
      input logic [31:0] e);
      apb(1'b1, ax(a, off), d);
      apb(1'b0, ax(a, off), 32'h0);
      chk("setting readback", e, rd);
   endtask : wr_rd
   // clamp level is the integer share of full scale, applied to both signs
   function automatic aftm_drive_t clampv(input int pct, input aftm_drive_t v);
      int l;
      l = pct * 32767 / 100;
      if (v > l) return aftm_drive_t'(l);
      if (v < -l) return aftm_drive_t'(-l);
      return v;
   endfunction : clampv
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      int a, r, p;
      aftm_drive_t v;
      void'($urandom(32'h823B));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk("outputs idle", 8'hFF, gpo_n);
      for (a = 0; a < 4; a++) begin
         for (r = 0; r < 6; r++) begin
            apb(1'b0, ax(a, roff[r]), 32'h0);
            chk("reset value", (a == 0 && r == 4) ? 32'h1 : rval[r], rd);
         end
      end
      apb(1'b0, `AFTM_OFF_OUT_STATE, 32'h0);
      chk("output state", 32'hFF, rd);
      wr_rd(3, `AFTM_OFF_ILIM, 32'hFFFFFFFF, 32'h7FFFFF);
      wr_rd(3, `AFTM_OFF_RMS_PCT, 32'h65, 32'h64);
      wr_rd(3, `AFTM_OFF_RMS_TIME, 32'h0, 32'h1);
      wr_rd(3, `AFTM_OFF_RMS_TIME, 32'h3FFF, 32'h3FFF);
      wr_rd(3, `AFTM_OFF_CLAMP, 32'h7F, 32'h64);
      apb(1'b0, 8'hFC, 32'h0);
      chk("unmapped error", 1, er);
      $display("register test done");
      // integral trap, aux output and interrupt per axis
      for (a = 0; a < 4; a++) begin
         r = (a == 0) ? 8388607 : (a == 1) ? 0 : $urandom % 8388607;
         apb(1'b1, ax(a, `AFTM_OFF_ILIM), r);
         ierr_cmd[a] <= r;
         cycles(6);
         apb(1'b0, `AFTM_OFF_STATUS, 32'h0);
         chk("no trap at limit", 0, rd);
         ierr_cmd[a] <= -(r + 1);
         cycles(6);
         apb(1'b0, `AFTM_OFF_STATUS, 32'h0);
         chk("integral trap", 32'h1 << (2 * a), rd);
         chk("aux masked off", 8'hFF, gpo_n);
         chk("irq masked", 0, irq);
         apb(1'b1, ax(a, `AFTM_OFF_AUX_MASK), 32'h1);
         apb(1'b1, ax(a, `AFTM_OFF_AUX_SEL), a + 5);
         cycles(3);
         chk("aux bit low", 8'(~(8'h1 << (a + 4))), gpo_n);
         apb(1'b1, ax(a, `AFTM_OFF_AUX_SEL), 32'h0);
         cycles(3);
         chk("aux disabled", 8'hFF, gpo_n);
         apb(1'b1, `AFTM_OFF_IRQ_MASK, 32'h1 << (2 * a));
         cycles(3);
         chk("irq raised", 1, irq);
         ierr_cmd[a] <= '0;
         cycles(3);
         apb(1'b1, `AFTM_OFF_STATUS, 32'hFF);
         cycles(3);
         chk("irq cleared", 0, irq);
         apb(1'b1, `AFTM_OFF_IRQ_MASK, 32'h0);
         apb(1'b1, ax(a, `AFTM_OFF_AUX_MASK), 32'h0);
         $display("integral trap axis %0d done", a);
      end
      // clamp on axes 0 and 1 only, so axes 2 and 3 keep empty rms sums
      for (a = 0; a < 4; a++) apb(1'b1, ax(a, `AFTM_OFF_RMS_PCT), 32'h64);
      for (r = 0; r < 12; r++) begin
         a = r % 2;
         p = (r == 0) ? 0 : (r == 1) ? 100 : $urandom % 101;
         v = (r < 2) ? -16'sd32768 : aftm_drive_t'($urandom);
         apb(1'b1, ax(a, `AFTM_OFF_CLAMP), p);
         drive_cmd[a] <= v;
         cycles(4);
         chk("clamped drive", 32'(clampv(p, v)), 32'(amp_seen[a]));
         drive_cmd[a] <= '0;
      end
      apb(1'b0, `AFTM_OFF_STATUS, 32'h0);
      chk("no clamp fault", 0, rd);
      $display("clamp test done");
      // sustained overload slightly above a 10 percent level over a 10 ms window
      apb(1'b1, ax(2, `AFTM_OFF_RMS_PCT), 32'hA);
      apb(1'b1, ax(2, `AFTM_OFF_RMS_TIME), 32'hA);
      apb(1'b1, `AFTM_OFF_IRQ_MASK, 32'hA0);
      drive_cmd[2] <= 16'sd3376;
      wait_irq(120);
      chk("rms not early", 1, cyc >= 32);
      chk("rms window trip", 1, cyc < 120);
      // ten times the level over a 100 ms window must trip after two samples
      drive_cmd[2] <= '0;
      apb(1'b1, ax(3, `AFTM_OFF_RMS_PCT), 32'hA);
      apb(1'b1, ax(3, `AFTM_OFF_RMS_TIME), 32'h64);
      apb(1'b1, `AFTM_OFF_STATUS, 32'hFF);
      drive_cmd[3] <= 16'sd32760;
      wait_irq(40);
      chk("rms early trip", 1, cyc < 30);
      apb(1'b0, `AFTM_OFF_STATUS, 32'h0);
      chk("rms status", 32'h80, rd);
      // full-scale drive with the limit at 100 percent never trips
      drive_cmd[3] <= '0;
      apb(1'b1, ax(2, `AFTM_OFF_RMS_PCT), 32'h64);
      apb(1'b1, ax(2, `AFTM_OFF_RMS_TIME), 32'h1);
      apb(1'b1, `AFTM_OFF_STATUS, 32'hFF);
      drive_cmd[2] <= 16'sd32767;
      wait_irq(60);
      chk("rms never at full", 60, cyc);
      $display("rms trap test done");
      report_and_stop();
   end
endmodule : tb_axis_fault_trap_monitor
